/* File: common/spfr_pkg.sv */
// Package: constants, carriers and frame-type decoding for the payload parser
package spfr_pkg;
	// Entry storage and register map
	localparam int unsigned MAX_ENTRIES = 16;
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_REQ    = 4'h8;
	localparam logic [3:0] ADDR_COUNT  = 4'hc;
	localparam int unsigned CTRL_EN_BIT  = 0;
	localparam int unsigned CTRL_HFO_BIT = 1;
	localparam logic [1:0] CTRL_RESET   = 2'h1;
	// Sticky status bit positions
	localparam int unsigned ST_RSV    = 0;
	localparam int unsigned ST_HDR    = 1;
	localparam int unsigned ST_ORDER  = 2;
	localparam int unsigned ST_TRUNC  = 3;
	localparam int unsigned ST_SIDMSB = 4;
	localparam int unsigned ST_BAD    = 5;
	localparam int unsigned ST_EXTRA  = 6;
	localparam int unsigned STATUS_W  = 7;
	// Rate index codes with special meaning
	localparam logic [3:0] RATE_PRI_MAX = 4'hb;
	localparam logic [3:0] RATE_SID_PRI = 4'hc;
	localparam logic [3:0] RATE_IOP_MAX = 4'h8;
	localparam logic [3:0] RATE_SID_IOP = 4'h9;
	localparam logic [3:0] RATE_LOST    = 4'he;
	localparam logic [3:0] RATE_EMPTY   = 4'hf;
	// Speech bits per 20 ms frame, indexed by rate code
	localparam logic [11:0] PRI_BITS [0:12] = '{12'h038, 12'h090, 12'h0a0, 12'h0c0, 12'h108, 12'h148,
		12'h1e8, 12'h280, 12'h3c0, 12'h500, 12'h780, 12'ha00, 12'h030};
	localparam logic [11:0] IOP_BITS [0:9] = '{12'h084, 12'h0b1, 12'h0fd, 12'h11d, 12'h13d, 12'h16d,
		12'h18d, 12'h1cd, 12'h1dd, 12'h028};

	typedef struct packed {
		logic       hdrType;
		logic       followOn;
		logic       modeSel;
		logic       qualBit;
		logic [3:0] rateIdx;
	} spfr_toc_t;

	typedef struct packed {
		logic [7:0] data;
		logic [3:0] validBits;
		logic       frameFirst;
		logic       frameLast;
		logic [3:0] frameIdx;
	} spfr_beat_t;

	typedef struct packed {
		logic [3:0] frameIdx;
		spfr_toc_t  toc;
		logic       badFrame;
		logic       noSpeech;
	} spfr_info_t;

	typedef enum logic [1:0] {S_HDR, S_LOAD, S_DATA, S_SKIP} spfr_state_t;

	// Reserved codes, including a primary frame with its unused bit set
	function automatic logic spfr_is_reserved(spfr_toc_t t);
		if (!t.modeSel)
			return t.qualBit || (t.rateIdx == RATE_SID_PRI + 4'h1);
		return (t.rateIdx > RATE_SID_IOP) && (t.rateIdx < RATE_LOST);
	endfunction

	// Speech bit count carried by one entry; lost and empty carry none
	function automatic logic [11:0] spfr_frame_bits(spfr_toc_t t);
		if (t.rateIdx >= RATE_LOST || spfr_is_reserved(t))
			return 12'h000;
		if (!t.modeSel)
			return PRI_BITS[t.rateIdx];
		return IOP_BITS[t.rateIdx];
	endfunction
endpackage

/* File: hdl/spfr_toc_parser.sv */
// Receiver that parses full-header speech payloads into frames
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none

// Operation
// RULE1 - Entry bytes carry header type zero
// RULE2 - Top bit: one request, zero entry
// RULE3 - Request byte only before all entries
// RULE4 - Follow-on bit chains entries, zero ends
// RULE5 - Frame type: mode, quality, rate index
// RULE6 - Primary rate codes map to twelve rates
// RULE7 - Primary comfort noise, reserved, lost, empty
// RULE8 - Interop rates, comfort noise, reserved, lost, empty
// RULE9 - Interop frame quality zero is damaged
// RULE10 - Sender drops all-empty and trailing empty blocks
// RULE11 - Sender drops leading empty blocks
// RULE12 - Speech bits leftmost, right after headers
// RULE13 - Sender zero-pads interop frames to octets
// RULE14 - Receiver discards octet pad bits
// RULE15 - Interop comfort noise: 40 bits, top bit one
// RULE16 - Sender pads colliding sizes with zero bytes
// RULE17 - Interop comfort noise 56-bit payload unpadded
// RULE18 - Further padding only through transport padding
// RULE19 - Sender uses compact form for lone frames
// RULE20 - Sender uses full header otherwise
// RULE21 - Sender may use full header for two rates
// RULE22 - Full-header-only option forbids collision padding
// RULE23 - Receiver takes mode from entry byte
// RULE24 - One byte per cycle, flag reserved codes
module spfr_toc_parser
	import spfr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  inByte,
	input  wire logic        inValid,
	input  wire logic        inLast,
	output logic             inReady,
	output spfr_beat_t       beat,
	output logic             beatValid,
	output spfr_info_t       info,
	output logic             infoValid,
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wrData,
	input  wire logic        wrEn,
	input  wire logic        rdEn,
	output logic [31:0]      rdData
);

	// ************************************************************
	// Parser state
	// ************************************************************
	spfr_state_t state_q, state_d;
	spfr_toc_t   toc_q [0:MAX_ENTRIES-1];
	spfr_toc_t   toc_d [0:MAX_ENTRIES-1];
	logic [4:0]  nToc_q, nToc_d;
	logic [3:0]  cur_q, cur_d;
	logic [11:0] bitsLeft_q, bitsLeft_d;
	logic        firstByte_q, firstByte_d;
	logic        frameFirst_q, frameFirst_d;
	logic        lastSeen_q, lastSeen_d;
	logic        ready_q, ready_d;
	spfr_beat_t  beat_q, beat_d;
	logic        beatValid_q, beatValid_d;
	spfr_info_t  info_q, info_d;
	logic        infoValid_q, infoValid_d;
	logic [8:0]  req_q, req_d;
	logic [15:0] count_q, count_d;
	logic [STATUS_W-1:0] set;

	// ************************************************************
	// Register state
	// ************************************************************
	logic [1:0]          ctrl_q, ctrl_d;
	logic [STATUS_W-1:0] status_q, status_d;
	logic [31:0]         rdData_q, rdData_d;

	spfr_toc_t   inToc;
	spfr_toc_t   curToc;
	logic        take;
	logic [3:0]  nBits;
	logic [7:0]  padMask;

	assign inToc  = spfr_toc_t'(inByte);
	assign curToc = toc_q[cur_q];
	assign take   = inValid && ready_q;

	// Next-state logic for the parser
	always_comb begin
		state_d      = state_q;
		toc_d        = toc_q;
		nToc_d       = nToc_q;
		cur_d        = cur_q;
		bitsLeft_d   = bitsLeft_q;
		firstByte_d  = firstByte_q;
		frameFirst_d = frameFirst_q;
		lastSeen_d   = lastSeen_q;
		beat_d       = beat_q;
		beatValid_d  = 1'b0;
		info_d       = info_q;
		infoValid_d  = 1'b0;
		req_d        = req_q;
		count_d      = count_q;
		set          = '0;
		nBits        = (bitsLeft_q >= 12'h008) ? 4'h8 : bitsLeft_q[3:0];
		padMask      = 8'hff << (4'h8 - nBits); // Octet pad of interop frames [RULE13]
		case (state_q)
			S_HDR: begin
				if (take) begin
					firstByte_d = 1'b0;
					if (inToc.hdrType) begin // [RULE2]
						if (firstByte_q)
							req_d = {1'b1, inByte}; // Request persists until replaced
						else
							set[ST_ORDER] = 1'b1; // [RULE1] [RULE3]
					end else if (nToc_q == 5'(MAX_ENTRIES)) begin
						set[ST_HDR] = 1'b1; // Entry table full, drop payload
						state_d = S_SKIP;
					end else begin
						toc_d[nToc_q[3:0]] = inToc; // Full-header form, up to MAX_ENTRIES frames [RULE19] [RULE20] [RULE21]
						nToc_d = nToc_q + 5'h01;
						if (!inToc.followOn) begin // [RULE4]
							cur_d   = 4'h0;
							state_d = S_LOAD;
						end
					end
					if (inLast) begin
						lastSeen_d = 1'b1;
						if (state_d != S_LOAD) begin
							set[ST_TRUNC] = 1'b1;
							state_d = S_HDR;
						end
					end
				end
			end
			S_LOAD: begin
				// Mode and rate come from the entry alone, whatever the size [RULE23] [RULE5]
				bitsLeft_d       = spfr_frame_bits(curToc); // [RULE6] [RULE8]
				frameFirst_d     = 1'b1;
				info_d.frameIdx  = cur_q;
				info_d.toc       = curToc;
				info_d.noSpeech  = (curToc.rateIdx >= RATE_LOST); // [RULE7] [RULE10] [RULE11]
				info_d.badFrame  = curToc.modeSel && !curToc.qualBit &&
					(curToc.rateIdx < RATE_LOST); // [RULE9]
				infoValid_d      = 1'b1;
				count_d          = count_q + 16'h0001;
				set[ST_BAD]      = info_d.badFrame;
				state_d          = S_DATA;
				if (spfr_is_reserved(curToc)) begin
					set[ST_RSV] = 1'b1; // Length unknown, rest of payload unusable [RULE24]
					state_d = lastSeen_q ? S_HDR : S_SKIP;
				end else if (lastSeen_q && bitsLeft_d != 12'h000) begin
					set[ST_TRUNC] = 1'b1;
					state_d = S_HDR;
				end
			end
			S_DATA: begin
				if (bitsLeft_q == 12'h000) begin
					if ({1'b0, cur_q} + 5'h01 == nToc_q)
						state_d = lastSeen_q ? S_HDR : S_SKIP;
					else begin
						cur_d   = cur_q + 4'h1;
						state_d = S_LOAD;
					end
				end else if (take) begin
					// Bytes pass MSB first; octet pad bits forced to zero [RULE12] [RULE14]
					beat_d.data       = inByte & padMask;
					beat_d.validBits  = nBits;
					beat_d.frameFirst = frameFirst_q;
					beat_d.frameLast  = (bitsLeft_q <= 12'h008);
					beat_d.frameIdx   = cur_q;
					beatValid_d       = 1'b1;
					frameFirst_d      = 1'b0;
					bitsLeft_d        = bitsLeft_q - {8'h00, nBits};
					if (frameFirst_q && curToc.modeSel && curToc.rateIdx == RATE_SID_IOP && !inByte[7])
						set[ST_SIDMSB] = 1'b1; // [RULE15]
					if (inLast) begin
						lastSeen_d = 1'b1;
						if (bitsLeft_q > 12'h008) begin
							set[ST_TRUNC] = 1'b1;
							state_d = S_HDR;
						end
					end
				end
			end
			S_SKIP: begin
				// Collision pad bytes are dropped; none may appear in full-header-only use [RULE16] [RULE17] [RULE18] [RULE22]
				if (take) begin
					set[ST_EXTRA] = ctrl_q[CTRL_HFO_BIT];
					if (inLast)
						state_d = S_HDR;
				end
			end
			default: state_d = S_HDR;
		endcase
		if (state_d == S_HDR && (state_q != S_HDR || lastSeen_d)) begin // Also a header cut short by inLast
			nToc_d      = 5'h00;
			firstByte_d = 1'b1;
			lastSeen_d  = 1'b0;
		end
		// Accept a byte next cycle only where one is consumed
		ready_d = ctrl_q[CTRL_EN_BIT] && (state_d == S_HDR || state_d == S_SKIP ||
			(state_d == S_DATA && bitsLeft_d != 12'h000));
	end

	// Parser registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q      <= S_HDR;
			for (int i = 0; i < MAX_ENTRIES; i++)
				toc_q[i] <= '0;
			nToc_q       <= 5'h00;
			cur_q        <= 4'h0;
			bitsLeft_q   <= 12'h000;
			firstByte_q  <= 1'b1;
			frameFirst_q <= 1'b0;
			lastSeen_q   <= 1'b0;
			ready_q      <= 1'b0;
			beat_q       <= '0;
			beatValid_q  <= 1'b0;
			info_q       <= '0;
			infoValid_q  <= 1'b0;
			req_q        <= 9'h000;
			count_q      <= 16'h0000;
		end else begin
			state_q      <= state_d;
			toc_q        <= toc_d;
			nToc_q       <= nToc_d;
			cur_q        <= cur_d;
			bitsLeft_q   <= bitsLeft_d;
			firstByte_q  <= firstByte_d;
			frameFirst_q <= frameFirst_d;
			lastSeen_q   <= lastSeen_d;
			ready_q      <= ready_d;
			beat_q       <= beat_d;
			beatValid_q  <= beatValid_d;
			info_q       <= info_d;
			infoValid_q  <= infoValid_d;
			req_q        <= req_d;
			count_q      <= count_d;
		end
	end

	// ************************************************************
	// Register port
	// ************************************************************

	// Writes, write-one-to-clear status where a new event wins
	always_comb begin
		ctrl_d   = ctrl_q;
		status_d = status_q;
		rdData_d = 32'h00000000;
		if (wrEn && addr == ADDR_CTRL)
			ctrl_d = wrData[1:0];
		if (wrEn && addr == ADDR_STATUS)
			status_d = status_q & ~wrData[STATUS_W-1:0];
		status_d = status_d | set;
		if (rdEn) begin
			case (addr)
				ADDR_CTRL:   rdData_d = {30'h00000000, ctrl_q};
				ADDR_STATUS: rdData_d = {{(32-STATUS_W){1'b0}}, status_q};
				ADDR_REQ:    rdData_d = {23'h000000, req_q};
				ADDR_COUNT:  rdData_d = {16'h0000, count_q};
				default:     rdData_d = 32'h00000000;
			endcase
		end
	end

	// Register file flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q   <= CTRL_RESET;
			status_q <= '0;
			rdData_q <= 32'h00000000;
		end else begin
			ctrl_q   <= ctrl_d;
			status_q <= status_d;
			rdData_q <= rdData_d;
		end
	end

	assign inReady   = ready_q;
	assign beat      = beat_q;
	assign beatValid = beatValid_q;
	assign info      = info_q;
	assign infoValid = infoValid_q;
	assign rdData    = rdData_q;

endmodule // spfr_toc_parser

`default_nettype wire

/* File: verification/spfr_chk_sva.sv */
// Checker: timing and decoding relations at the parser ports
`timescale 1ns/100ps
`default_nettype none
module spfr_chk
	import spfr_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [7:0]  inByte,
	input wire logic        inValid,
	input wire logic        inReady,
	input wire spfr_beat_t  beat,
	input wire logic        beatValid,
	input wire spfr_info_t  info,
	input wire logic        infoValid,
	input wire logic        rdEn,
	input wire logic [31:0] rdData
);
	// ****
	// Port relations
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_entry_hdr: assert property (infoValid |-> !info.toc.hdrType)
		else $error("entry with request type");
	chk_load_gap: assert property (infoValid |-> !$past(inReady))
		else $error("no refusal cycle before frame info");
	chk_beat_src: assert property (beatValid |-> $past(inValid && inReady))
		else $error("beat without a taken byte");
	// Pad bits must be cleared, not passed on as speech
	chk_beat_data: assert property (beatValid |-> beat.data == ($past(inByte) & ~(8'hff >> beat.validBits)))
		else $error("beat data differs from input byte");
	chk_beat_bits: assert property (beatValid |-> beat.validBits inside {[4'h1:4'h8]})
		else $error("beat bit count out of range");
	chk_no_speech: assert property (infoValid |-> info.noSpeech == (info.toc.rateIdx >= RATE_LOST))
		else $error("lost or empty flag wrong");
	chk_bad_frame: assert property (infoValid && info.toc.modeSel && info.toc.rateIdx < RATE_LOST |-> info.badFrame == !info.toc.qualBit)
		else $error("damaged flag wrong");
	chk_rd_idle: assert property (!rdEn |=> rdData == 32'h0)
		else $error("read data outside its cycle");
endmodule // spfr_chk
bind spfr_toc_parser spfr_chk u_chk (.*);
`default_nettype wire

/* File: verification/spfr_rtp_src.sv */
// Model: transport side offering payload bytes
`timescale 1ns/100ps
`default_nettype none
module spfr_rtp_src (
	input  wire logic clk,
	input  wire logic inReady,
	output logic [7:0] inByte,
	output logic       inValid,
	output logic       inLast
);
	// ****
	// Byte sender; gap models a slow transport
	// ****
	initial begin
		inByte = 8'h00;
		inValid = 1'b0;
		inLast = 1'b0;
	end
	// Caller supplies the content unchecked, lawful or not: entry order, follow-on chain, octet pad
	task automatic send(input logic [7:0] pk[$], input int gap);
		int n;
		foreach (pk[i]) begin
			inByte <= pk[i];
			inLast <= (i == pk.size() - 1);
			inValid <= 1'b1;
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (!inReady && n < 200);
			@(posedge clk);
			if (n >= 200) begin
				tb_top.nErrors++;
				tb_top.conclude();
			end
			// Released line shows the inverse, never the stale byte
			if (gap > 0 || i == pk.size() - 1) begin
				inValid <= 1'b0;
				inLast <= 1'b0;
				inByte <= ~pk[i];
				repeat (gap) @(posedge clk);
			end
		end
	endtask
endmodule // spfr_rtp_src
`default_nettype wire

/* File: verification/tb_top.sv */
// Testbench: frames, codes and registers of the payload parser
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import spfr_pkg::*;
;
	logic        clk, rst_n, wrEn, rdEn, inReady, inValid, inLast, beatValid, infoValid;
	logic [7:0]  inByte;
	logic [3:0]  addr;
	logic [31:0] wrData, rdData, r;
	spfr_beat_t  beat, bq[$];
	spfr_info_t  info, iq[$];
	int          nErrors, checks;
	// ****
	// Design, transport model and collectors
	// ****
	spfr_toc_parser DUT (.clk(clk), .rst_n(rst_n), .inByte(inByte), .inValid(inValid), .inLast(inLast),
		.inReady(inReady), .beat(beat), .beatValid(beatValid), .info(info), .infoValid(infoValid),
		.addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData));
	spfr_rtp_src src (.clk(clk), .inReady(inReady), .inByte(inByte), .inValid(inValid), .inLast(inLast));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Sample mid-cycle so pulses are settled
	always @(negedge clk) begin
		if (beatValid) bq.push_back(beat);
		if (infoValid) iq.push_back(info);
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			nErrors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge clk);
		wrEn <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clk);
		rdEn <= 1'b0;
		@(negedge clk);
		r = rdData;
		@(posedge clk);
	endtask
	task automatic frames(input logic [7:0] ex[$], input logic [3:0] lastBits);
		chk(32'(bq.size()), 32'(ex.size()));
		foreach (ex[i]) if (i < bq.size()) chk(bq[i].data, ex[i]);
		if (bq.size() > 0) begin
			chk(32'(bq[$].validBits), 32'(lastBits));
			chk(32'(bq[0].frameFirst), 32'h1);
			chk(32'(bq[$].frameLast), 32'h1);
		end
		bq.delete();
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_regs();
		rd(ADDR_CTRL);
		chk(r, 32'h1);
		wr(4'h2, 32'hffffffff);
		rd(4'h2);
		chk(r, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_primary();
		logic [7:0] p[$];
		p = '{8'h00, 8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'he5, 8'hf6, 8'h17};
		src.send(p, 0);
		repeat (4) @(posedge clk);
		chk(32'(iq[0]), 32'({4'h0, 8'h00, 2'b00}));
		frames(p[1:$], 4'h8);
		iq.delete();
		$display("test primary done");
	endtask
	// Request byte, lost entry chained to a comfort-noise entry, slow sender
	task automatic t_multi();
		logic [7:0] p[$];
		p = '{8'h8b, 8'h4e, 8'h39, 8'hc1, 8'h22, 8'h33, 8'h44, 8'h55};
		src.send(p, 2);
		repeat (4) @(posedge clk);
		chk(iq[0], {4'h0, 8'h4e, 2'b01});
		chk(iq[1], {4'h1, 8'h39, 2'b00});
		chk(32'(bq[0].frameIdx), 32'h1);
		frames(p[3:$], 4'h8);
		rd(ADDR_REQ);
		chk(r, 32'h18b);
		iq.delete();
		$display("test multi done");
	endtask
	// Damaged interop frame: 132 bits, last byte carries four
	task automatic t_iop();
		logic [7:0] p[$], ex[$];
		p = '{8'h20};
		repeat (17) p.push_back(8'hff);
		ex = p[1:16];
		ex.push_back(8'hf0);
		src.send(p, 0);
		repeat (4) @(posedge clk);
		chk(32'(iq[0]), 32'({4'h0, 8'h20, 2'b10}));
		frames(ex, 4'h4);
		rd(ADDR_STATUS);
		chk(r, 32'h20);
		wr(ADDR_STATUS, 32'h7f);
		iq.delete();
		$display("test interop done");
	endtask
	task automatic t_codes();
		logic rsv;
		for (int m = 0; m < 2; m++) for (int c = 0; c < 16; c++) begin
			rsv = m ? (c > 9 && c < 14) : (c == 13);
			src.send('{{2'b00, m[0], m[0], c[3:0]}}, 0);
			repeat (3) @(posedge clk);
			chk(32'(iq.size()), 32'h1);
			chk(32'(iq[0].toc.rateIdx), 32'(c[3:0]));
			chk(32'(iq[0].noSpeech), 32'(c >= 14));
			rd(ADDR_STATUS);
			chk(r[ST_RSV], rsv);
			wr(ADDR_STATUS, 32'h7f);
			iq.delete();
			bq.delete();
		end
		$display("test codes done");
	endtask
	// Disable, misplaced request, trailing bytes, table overflow, comfort-noise top bit
	task automatic t_errors();
		logic [7:0] p[$];
		wr(ADDR_CTRL, 32'h0);
		@(negedge clk);
		chk(32'(inReady), 32'h0);
		@(posedge clk);
		wr(ADDR_CTRL, 32'h3);
		p = '{8'h4e, 8'h85, 8'h0f, 8'h00};
		src.send(p, 0);
		repeat (4) @(posedge clk);
		chk(32'(iq.size()), 32'h2);
		chk(32'(iq[1]), 32'({4'h1, 8'h0f, 2'b01}));
		rd(ADDR_STATUS);
		chk(r, 32'h44);
		rd(ADDR_REQ);
		chk(r, 32'h18b);
		wr(ADDR_STATUS, 32'h7f);
		wr(ADDR_CTRL, 32'h1);
		iq.delete();
		// Seventeen chained entries overflow the table; next payload must parse afresh
		p.delete();
		repeat (17) p.push_back(8'h4e);
		src.send(p, 0);
		repeat (4) @(posedge clk);
		chk(32'(iq.size()), 32'h0);
		rd(ADDR_STATUS);
		chk(r, 32'h0a);
		wr(ADDR_STATUS, 32'h7f);
		// Request plus comfort-noise entry fills 56 bits, first data bit zero
		p = '{8'h81, 8'h39, 8'h41, 8'h22, 8'h33, 8'h44, 8'h55};
		src.send(p, 0);
		repeat (4) @(posedge clk);
		chk(32'(iq.size()), 32'h1);
		frames(p[2:$], 4'h8);
		rd(ADDR_STATUS);
		chk(r, 32'h10);
		rd(ADDR_REQ);
		chk(r, 32'h181);
		// Frames loaded so far across all scenarios, in this order
		rd(ADDR_COUNT);
		chk(r, 32'h27);
		wr(ADDR_STATUS, 32'h7f);
		iq.delete();
		$display("test errors done");
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", checks, nErrors);
		if (nErrors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		addr = 4'h0;
		wrData = 32'h0;
		wrEn = 1'b0;
		rdEn = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_regs();
		t_primary();
		t_multi();
		t_iop();
		t_codes();
		t_errors();
		conclude();
	end
endmodule // tb_top
`default_nettype wire
